/* acke_pkg.sv */
// Shared constants, types and helpers for the AES cipher and key expander
package acke_pkg;

  // Key length selector codes
  localparam logic [1:0] KSEL_128 = 2'h0;
  localparam logic [1:0] KSEL_192 = 2'h1;
  localparam logic [1:0] KSEL_256 = 2'h2;

  // Round counts per key length
  localparam logic [3:0] NR_128 = 4'ha;
  localparam logic [3:0] NR_192 = 4'hc;
  localparam logic [3:0] NR_256 = 4'he;

  // Raw key length in words
  localparam logic [3:0] NK_128 = 4'h4;
  localparam logic [3:0] NK_192 = 4'h6;
  localparam logic [3:0] NK_256 = 4'h8;

  // Block geometry and schedule positions
  localparam logic [5:0] BLOCK_WORDS  = 6'h04;
  localparam logic [2:0] OUT_WORDS    = 3'h4;
  localparam logic [5:0] POS_SUB_ONLY = 6'h04;

  // Field constants
  localparam logic [7:0] GF_POLY      = 8'h1b;
  localparam logic [7:0] AFFINE_C     = 8'h63;
  localparam logic [7:0] INV_AFFINE_C = 8'h05;
  localparam logic [7:0] RCON_FIRST   = 8'h01;

  // Column mix coefficients, forward and inverse
  localparam logic [7:0] MIX_C0  = 8'h02;
  localparam logic [7:0] MIX_C1  = 8'h03;
  localparam logic [7:0] MIX_C2  = 8'h01;
  localparam logic [7:0] MIX_C3  = 8'h01;
  localparam logic [7:0] IMIX_C0 = 8'h0e;
  localparam logic [7:0] IMIX_C1 = 8'h0b;
  localparam logic [7:0] IMIX_C2 = 8'h0d;
  localparam logic [7:0] IMIX_C3 = 8'h09;

  // Key expander states
  typedef enum logic [1:0] {KX_IDLE, KX_LOAD, KX_FWD, KX_BWD} acke_kx_e;

  function automatic logic [3:0] numRounds(input logic [1:0] ks);
    case (ks)
      KSEL_192: numRounds = NR_192;
      KSEL_256: numRounds = NR_256;
      default:  numRounds = NR_128;
    endcase
  endfunction

  function automatic logic [3:0] nkOf(input logic [1:0] ks);
    case (ks)
      KSEL_192: nkOf = NK_192;
      KSEL_256: nkOf = NK_256;
      default:  nkOf = NK_128;
    endcase
  endfunction

  // Words per operation: four per round key
  function automatic logic [5:0] opWords(input logic [1:0] ks);
    return {numRounds(ks), 2'h0} + BLOCK_WORDS;
  endfunction

  function automatic logic [7:0] xtime(input logic [7:0] b);
    return {b[6:0], 1'b0} ^ (b[7] ? GF_POLY : 8'h00);
  endfunction

  // Round constant for schedule round n (n from 1)
  function automatic logic [7:0] rconOf(input logic [5:0] n);
    logic [7:0] r;
    r = RCON_FIRST;
    for (int i = 1; i < 15; i++) begin
      if (i < int'(n)) begin
        r = xtime(r);
      end
    end
    return r;
  endfunction

endpackage

/* acke_col_if.sv */
// Column transform carrier between the control logic and the transform
`timescale 1ns/100ps
interface acke_col_if;
  logic [31:0] colIn;
  logic        inv;
  logic        mix;
  logic [31:0] colOut;
  modport xf   (input colIn, inv, mix, output colOut);
  modport user (output colIn, inv, mix, input colOut);
endinterface

/* acke_col_xform.sv */
// Byte substitution and optional column mix on one 32-bit column
`timescale 1ns/100ps
module acke_col_xform
  import acke_pkg::*;
(
  // Column carrier
  acke_col_if.xf cx
);

  function automatic logic [7:0] gfMul(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] p;
    logic [7:0] t;
    p = 8'h00;
    t = a;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) begin
        p = p ^ t;
      end
      t = xtime(t);
    end
    return p;
  endfunction

  // Inverse as x^254; zero maps to zero
  function automatic logic [7:0] gfInv(input logic [7:0] x);
    logic [7:0] y;
    y = x;
    for (int i = 0; i < 6; i++) begin
      y = gfMul(gfMul(y, y), x);
    end
    return gfMul(y, y);
  endfunction

  function automatic logic [7:0] rotl(input logic [7:0] b, input int n);
    logic [15:0] t;
    t = {b, b} << n;
    return t[15:8];
  endfunction

  function automatic logic [7:0] sbox(input logic [7:0] x);
    logic [7:0] i;
    i = gfInv(x);
    return i ^ rotl(i, 1) ^ rotl(i, 2) ^ rotl(i, 3) ^ rotl(i, 4) ^ AFFINE_C;
  endfunction

  function automatic logic [7:0] invSbox(input logic [7:0] x);
    return gfInv(rotl(x, 1) ^ rotl(x, 3) ^ rotl(x, 6) ^ INV_AFFINE_C);
  endfunction

  logic [7:0]  sub [4];
  logic [31:0] mixed;

  // Substitute each byte, then mix the column when asked
  always_comb begin
    for (int r = 0; r < 4; r++) begin
      sub[r] = cx.inv ? invSbox(cx.colIn[31-8*r -: 8]) : sbox(cx.colIn[31-8*r -: 8]);
    end
    for (int r = 0; r < 4; r++) begin
      mixed[31-8*r -: 8] = cx.inv ?
        gfMul(sub[r], IMIX_C0) ^ gfMul(sub[(r+1)%4], IMIX_C1) ^
        gfMul(sub[(r+2)%4], IMIX_C2) ^ gfMul(sub[(r+3)%4], IMIX_C3) :
        gfMul(sub[r], MIX_C0) ^ gfMul(sub[(r+1)%4], MIX_C1) ^
        gfMul(sub[(r+2)%4], MIX_C2) ^ gfMul(sub[(r+3)%4], MIX_C3);
    end
    cx.colOut = cx.mix ? mixed : {sub[0], sub[1], sub[2], sub[3]};
  end

endmodule

/* acke_cipher_top.sv */
// AES cipher engine with pre-expanded key and on-the-fly key expander
//
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
module acke_cipher_top
  import acke_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_low,
  // Cipher engine control
  input  wire logic        en,
  input  wire logic        go,
  input  wire logic        dir,
  input  wire logic [1:0]  keyLengthSel,
  // Cipher engine data
  input  wire logic [31:0] keyWord,
  input  wire logic [31:0] dataWord,
  output logic             dataReq,
  output logic [31:0]      resultWord,
  output logic             resultValid,
  // Key expander control
  input  wire logic        kxEn,
  input  wire logic        kxGo,
  input  wire logic        kxDir,
  input  wire logic [1:0]  kxKsel,
  // Key expander data
  input  wire logic [31:0] rawCipherWord,
  output logic             kxKeyReq,
  output logic [31:0]      kxKeyWord,
  output logic [5:0]       kxKeyAddr,
  output logic             kxKeyValid,
  output logic             kxKeyLast
);

  ////////////////////////////////////////////////////////////////////////////
  // Cipher engine

  logic         busy_q;
  logic         goPrev_q;
  logic         dec_q;
  logic [5:0]   cnt_q;
  logic [31:0]  shadow_q [3];
  logic [127:0] state_q;
  logic [127:0] outBuf_q;
  logic [2:0]   outCnt_q;
  logic [3:0]   nr;
  logic [5:0]   total;
  logic         fin;
  logic         start;
  logic         done;
  logic         step;
  logic [31:0]  gathered;
  logic [31:0]  newCol;

  acke_col_if engIf ();

  acke_col_xform u_engXform (
    .cx (engIf.xf)
  );

  assign nr    = numRounds(keyLengthSel);
  assign total = opWords(keyLengthSel);
  assign fin   = (cnt_q[5:2] == nr);
  assign start = go && !goPrev_q;
  assign step  = en && busy_q && go;
  assign done  = step && (cnt_q == total - 6'h01);

  // Trigger history, frozen while disabled
  always_ff @(posedge clk) begin
    if (!reset_low) begin
      goPrev_q <= 1'b0;
    end else if (en) begin
      goPrev_q <= go;
    end
  end

  // Shift rows: pick the source byte for each row of this column
  always_comb begin
    logic [1:0] src;
    src      = 2'h0;
    gathered = 32'h0;
    for (int r = 0; r < 4; r++) begin
      src = dec_q ? cnt_q[1:0] - 2'(r) : cnt_q[1:0] + 2'(r);
      gathered[31-8*r -: 8] = state_q[127 - 32*int'(src) - 8*r -: 8];
    end
  end

  // substitution, shift and mix per column; no mix in the final round
  assign engIf.colIn = gathered;
  assign engIf.inv   = dec_q;
  assign engIf.mix   = !fin;

  // key added to data first, then to each round column
  assign newCol = (cnt_q < BLOCK_WORDS) ? (dataWord ^ keyWord) : (engIf.colOut ^ keyWord);

  // Operation sequencing
  always_ff @(posedge clk) begin
    if (!reset_low) begin
      busy_q <= 1'b0;
      dec_q  <= 1'b0;
      cnt_q  <= 6'h00;
    end else if (en) begin
      if (!busy_q) begin
        if (start) begin
          busy_q <= 1'b1;
          cnt_q  <= 6'h00;
          dec_q  <= dir;
        end
      end else if (!go) begin
        busy_q <= 1'b0;
        cnt_q  <= 6'h00;
      end else if (done) begin
        cnt_q <= 6'h00;
        dec_q <= dir;
      end else begin
        cnt_q <= cnt_q + 6'h01;
      end
    end
  end

  // State storage: three columns staged, fourth completes the round
  always_ff @(posedge clk) begin
    if (!reset_low) begin
      state_q <= 128'h0;
      for (int i = 0; i < 3; i++) begin
        shadow_q[i] <= 32'h0;
      end
    end else if (step) begin
      // column zero is the first word
      if (cnt_q[1:0] == 2'h3) begin
        state_q <= {shadow_q[0], shadow_q[1], shadow_q[2], newCol};
      end else begin
        shadow_q[cnt_q[1:0]] <= newCol;
      end
    end
  end

  // Result buffer streams out while the next block loads
  always_ff @(posedge clk) begin
    if (!reset_low) begin
      outBuf_q <= 128'h0;
      outCnt_q <= 3'h0;
    end else if (en) begin
      if (done) begin
        outBuf_q <= {shadow_q[0], shadow_q[1], shadow_q[2], newCol};
        outCnt_q <= OUT_WORDS;
      end else if (outCnt_q != 3'h0) begin
        outBuf_q <= {outBuf_q[95:0], 32'h0};
        outCnt_q <= outCnt_q - 3'h1;
      end
    end
  end

  // data request during the first four words
  assign dataReq     = busy_q && (cnt_q < BLOCK_WORDS);
  assign resultWord  = outBuf_q[127:96];
  assign resultValid = (outCnt_q != 3'h0);

  ////////////////////////////////////////////////////////////////////////////
  // Key expander

  acke_kx_e    kxState_q;
  logic        kxGoPrev_q;
  logic        kxDec_q;
  logic [5:0]  kxIdx_q;
  logic [31:0] kxWin_q [8];
  logic [31:0] kxWord_q;
  logic [5:0]  kxAddr_q;
  logic        kxValid_q;
  logic        kxLast_q;
  logic [3:0]  kxNk;
  logic [5:0]  kxLastIdx;
  logic [5:0]  kxPos;
  logic [5:0]  kxRnd;
  logic [31:0] kxSrc;
  logic [31:0] kxTemp;
  logic [31:0] kxFwdWord;
  logic [31:0] kxBwdWord;
  logic        kxRun;

  acke_col_if kxIf ();

  acke_col_xform u_kxXform (
    .cx (kxIf.xf)
  );

  assign kxNk      = nkOf(kxKsel);
  assign kxLastIdx = opWords(kxKsel) - 6'h01;
  assign kxPos     = 6'(kxIdx_q % {2'h0, kxNk});
  assign kxRnd     = 6'(kxIdx_q / {2'h0, kxNk});
  assign kxRun     = kxEn && kxGo;

  // Previous word: newest forward, second newest backward
  assign kxSrc     = (kxState_q == KX_BWD) ? kxWin_q[1] : kxWin_q[0];
  assign kxIf.colIn = (kxPos == 6'h00) ? {kxSrc[23:0], kxSrc[31:24]} : kxSrc;
  assign kxIf.inv  = 1'b0;
  assign kxIf.mix  = 1'b0;

  // Schedule temporary word for index kxIdx_q
  always_comb begin
    if (kxPos == 6'h00) begin
      kxTemp = kxIf.colOut ^ {rconOf(kxRnd), 24'h0};
    end else if ((kxNk == NK_256) && (kxPos == POS_SUB_ONLY)) begin
      kxTemp = kxIf.colOut;
    end else begin
      kxTemp = kxSrc;
    end
  end

  assign kxFwdWord = kxWin_q[3'(kxNk - 4'h1)] ^ kxTemp;
  assign kxBwdWord = kxWin_q[0] ^ kxTemp;

  // Trigger history, frozen while disabled
  always_ff @(posedge clk) begin
    if (!reset_low) begin
      kxGoPrev_q <= 1'b0;
    end else if (kxEn) begin
      kxGoPrev_q <= kxGo;
    end
  end

  // Expander sequencing
  always_ff @(posedge clk) begin
    if (!reset_low) begin
      kxState_q <= KX_IDLE;
      kxIdx_q   <= 6'h00;
      kxDec_q   <= 1'b0;
    end else if (kxEn) begin
      case (kxState_q)
        KX_IDLE: begin
          if (kxGo && !kxGoPrev_q) begin
            kxState_q <= KX_LOAD;
            kxIdx_q   <= 6'h00;
            kxDec_q   <= kxDir;
          end
        end
        KX_LOAD: begin
          if (!kxGo) begin
            kxState_q <= KX_IDLE;
          end else begin
            kxIdx_q <= kxIdx_q + 6'h01;
            if (kxIdx_q == 6'(kxNk - 4'h1)) begin
              kxState_q <= KX_FWD;
            end
          end
        end
        KX_FWD: begin
          if (!kxGo) begin
            kxState_q <= KX_IDLE;
          end else if (kxIdx_q == kxLastIdx) begin
            // decryption walks back from the end
            if (kxDec_q) begin
              kxState_q <= KX_BWD;
            end else begin
              // next raw key requested at once
              kxState_q <= KX_LOAD;
              kxIdx_q   <= 6'h00;
              kxDec_q   <= kxDir;
            end
          end else begin
            kxIdx_q <= kxIdx_q + 6'h01;
          end
        end
        KX_BWD: begin
          if (!kxGo) begin
            kxState_q <= KX_IDLE;
          end else if (kxIdx_q == 6'h00) begin
            // next raw key requested at once
            kxState_q <= KX_LOAD;
            kxDec_q   <= kxDir;
          end else begin
            kxIdx_q <= kxIdx_q - 6'h01;
          end
        end
        default: begin
          kxState_q <= KX_IDLE;
        end
      endcase
    end
  end

  // Sliding window of the last eight schedule words
  always_ff @(posedge clk) begin
    if (!reset_low) begin
      for (int i = 0; i < 8; i++) begin
        kxWin_q[i] <= 32'h0;
      end
    end else if (kxRun && (kxState_q == KX_BWD)) begin
      for (int i = 0; i < 8; i++) begin
        if (i == int'(kxNk) - 1) begin
          kxWin_q[i] <= kxBwdWord;
        end else if (i < 7) begin
          kxWin_q[i] <= kxWin_q[i+1];
        end
      end
    end else if (kxRun && (kxState_q != KX_IDLE)) begin
      kxWin_q[0] <= (kxState_q == KX_LOAD) ? rawCipherWord : kxFwdWord;
      for (int i = 1; i < 8; i++) begin
        kxWin_q[i] <= kxWin_q[i-1];
      end
    end
  end

  // Registered expanded word, address and flags
  always_ff @(posedge clk) begin
    if (!reset_low) begin
      kxWord_q  <= 32'h0;
      kxAddr_q  <= 6'h00;
      kxValid_q <= 1'b0;
      kxLast_q  <= 1'b0;
    end else if (kxEn) begin
      kxAddr_q  <= kxIdx_q;
      kxValid_q <= kxGo && ((kxState_q == KX_BWD) ||
                   (!kxDec_q && ((kxState_q == KX_LOAD) || (kxState_q == KX_FWD))));
      kxLast_q  <= kxGo && (((kxState_q == KX_BWD) && (kxIdx_q == 6'h00)) ||
                   (!kxDec_q && (kxState_q == KX_FWD) && (kxIdx_q == kxLastIdx)));
      case (kxState_q)
        KX_LOAD: kxWord_q <= rawCipherWord;
        KX_FWD:  kxWord_q <= kxFwdWord;
        default: kxWord_q <= kxWin_q[0];
      endcase
    end
  end

  assign kxKeyReq   = (kxState_q == KX_LOAD);
  assign kxKeyWord  = kxWord_q;
  assign kxKeyAddr  = kxAddr_q;
  assign kxKeyValid = kxValid_q;
  assign kxKeyLast  = kxLast_q;

endmodule

/* acke_cipher_asserts.sv */
// Port-level assertions for the AES cipher engine and key expander
`timescale 1ns/100ps
module acke_cipher_asserts
  import acke_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        reset_low,
  // Engine side
  input wire logic        en,
  input wire logic        go,
  input wire logic [1:0]  keyLengthSel,
  input wire logic        dataReq,
  input wire logic [31:0] resultWord,
  input wire logic        resultValid,
  // Expander side
  input wire logic        kxEn,
  input wire logic        kxGo,
  input wire logic        kxDir,
  input wire logic [1:0]  kxKsel,
  input wire logic        kxKeyReq,
  input wire logic [5:0]  kxKeyAddr,
  input wire logic        kxKeyValid,
  input wire logic        kxKeyLast
);
  // One clock for every check; one reset for all but reset_quiet_a
  default clocking @(posedge clk);
  endclocking
  default disable iff (!reset_low);

  ////////////////////////////////////////////////////////////
  // Engine
  start_req_a: assert property ($rose(go) && en && $past(en) |=> dataReq)
    else $error("no data request after start");
  data_len_a: assert property (disable iff (!reset_low || !en || !go)
    $rose(dataReq) |-> dataReq [*4] ##1 !dataReq) else $error("data request not four cycles");
  lat_128_a: assert property (disable iff (!reset_low || !en || !go)
    $rose(dataReq) && keyLengthSel == KSEL_128 |-> ##44 $rose(resultValid)) else $error("short key latency");
  lat_256_a: assert property (disable iff (!reset_low || !en || !go)
    $rose(dataReq) && keyLengthSel == KSEL_256 |-> ##60 $rose(resultValid)) else $error("long key latency");
  valid_len_a: assert property (disable iff (!reset_low || !en)
    $rose(resultValid) |-> resultValid [*4] ##1 !resultValid) else $error("result not four words");
  hold_en_a: assert property (!en |=> $stable(dataReq) && $stable(resultValid) && $stable(resultWord))
    else $error("engine moved while disabled");
  reset_quiet_a: assert property (disable iff (1'b0)
    !reset_low |=> !dataReq && !resultValid && !kxKeyReq && !kxKeyValid && !kxKeyLast) else $error("flags up in reset");

  ////////////////////////////////////////////////////////////
  // Expander
  kx_step_a: assert property (disable iff (!reset_low || !kxEn || !kxGo)
    kxKeyValid && !kxKeyLast && !kxDir |=> kxKeyValid && kxKeyAddr == $past(kxKeyAddr) + 6'h01)
    else $error("forward address not stepping");
  kx_last_a: assert property (kxKeyLast |-> kxKeyValid && kxKeyAddr == (kxDir ? 6'h00 :
    kxKsel == KSEL_192 ? 6'h33 : kxKsel == KSEL_256 ? 6'h3b : 6'h2b)) else $error("last word address");
  kx_reload_a: assert property (disable iff (!reset_low || !kxEn)
    kxKeyLast && kxGo && $past(kxGo) |-> kxKeyReq) else $error("no key request after last");
  kx_abort_a: assert property ($fell(kxGo) && kxEn |-> ##2 !kxKeyValid && !kxKeyReq)
    else $error("expansion not aborted");
endmodule

bind acke_cipher_top acke_cipher_asserts u_chk (.clk(clk), .reset_low(reset_low), .en(en), .go(go),
  .keyLengthSel(keyLengthSel), .dataReq(dataReq), .resultWord(resultWord), .resultValid(resultValid),
  .kxEn(kxEn), .kxGo(kxGo), .kxDir(kxDir), .kxKsel(kxKsel), .kxKeyReq(kxKeyReq),
  .kxKeyAddr(kxKeyAddr), .kxKeyValid(kxKeyValid), .kxKeyLast(kxKeyLast));

/* acke_host_model.sv */
// Host feeder: data block, raw key and expanded key pass-through
`timescale 1ns/100ps
module acke_host_model (
  // Clock, reset and enables
  input  wire logic        clk,
  input  wire logic        reset_low,
  input  wire logic        en,
  input  wire logic        kxEn,
  // Engine side
  input  wire logic        dataReq,
  output logic      [31:0] dataWord,
  output logic      [31:0] keyWord,
  // Expander side
  input  wire logic        kxKeyReq,
  input  wire logic        kxKeyValid,
  input  wire logic [31:0] kxKeyWord,
  output logic      [31:0] rawCipherWord
);
  logic [1:0]  dIdx_q;
  logic [2:0]  kIdx_q;
  logic [31:0] dLast_q;
  logic [31:0] kLast_q;

  // Word counters, cleared whenever a request ends
  always_ff @(posedge clk) begin
    dLast_q <= dataWord;
    kLast_q <= rawCipherWord;
    if (!reset_low || (en && !dataReq)) begin
      dIdx_q <= 2'h0;
    end else if (en) begin
      dIdx_q <= dIdx_q + 2'h1;
    end
    if (!reset_low || (kxEn && !kxKeyReq)) begin
      kIdx_q <= 3'h0;
    end else if (kxEn) begin
      kIdx_q <= kIdx_q + 3'h1;
    end
  end

  // one word per cycle, MSW first; idle lines toggle
  assign dataWord = dataReq ? {{2{dIdx_q, 2'h0}}, {2{dIdx_q, 2'h1}}, {2{dIdx_q, 2'h2}}, {2{dIdx_q, 2'h3}}}
                            : ~dLast_q;
  assign rawCipherWord = kxKeyReq ? {3'h0, kIdx_q, 2'h0, 3'h0, kIdx_q, 2'h1, 3'h0, kIdx_q, 2'h2, 3'h0, kIdx_q, 2'h3}
                                  : ~kLast_q;
  assign keyWord = kxKeyValid ? kxKeyWord : ~kxKeyWord;
endmodule

/* tb.sv */
// Self-checking bench for the AES cipher engine and key expander
`timescale 1ns/100ps
module tb;
  import acke_pkg::*;
  typedef struct {logic [1:0] ks; logic dr; int n; int nk; logic [127:0] res; int st;} acke_row_s;
  logic         clk = 1'b0, reset_low = 1'b0, en = 1'b0, go = 1'b0, dir = 1'b0, clr = 1'b1;
  logic         kxEn = 1'b0, kxGo = 1'b0, kxDir = 1'b0, lastSeen = 1'b0, ovl = 1'b0;
  logic [1:0]   keyLengthSel = 2'h0, kxKsel = 2'h0;
  logic [31:0]  keyWord, dataWord, rawCipherWord, resultWord, kxKeyWord;
  logic [5:0]   kxKeyAddr, lastAddr;
  logic [31:0]  lastWord;
  logic         dataReq, resultValid, kxKeyReq, kxKeyValid, kxKeyLast;
  logic [127:0] res;
  int           cyc = 1, tReq, tRv, tRv2, rvCnt, kvCnt, krCnt, n_errors = 0, total_checks = 0;
  acke_row_s    rows [6] = '{
    '{2'h0, 1'b0, 44, 4, 128'h69c4e0d86a7b0430d8cdb78070b4c55a, -10},
    '{2'h1, 1'b0, 52, 6, 128'hdda97ca4864cdfe06eaf70a0ec0d7191, -10},
    '{2'h2, 1'b0, 60, 8, 128'h8ea2b7ca516745bfeafc49904b496089, -10},
    '{2'h3, 1'b0, 44, 4, 128'h69c4e0d86a7b0430d8cdb78070b4c55a, -10},
    '{2'h0, 1'b1, 44, 4, 128'h0, -10},
    '{2'h2, 1'b1, 60, 8, 128'h0, -10}};

  always #5 clk = ~clk;

  acke_cipher_top dut (.clk(clk), .reset_low(reset_low), .en(en), .go(go), .dir(dir), .keyLengthSel(keyLengthSel),
    .keyWord(keyWord), .dataWord(dataWord), .dataReq(dataReq), .resultWord(resultWord),
    .resultValid(resultValid), .kxEn(kxEn), .kxGo(kxGo), .kxDir(kxDir), .kxKsel(kxKsel),
    .rawCipherWord(rawCipherWord), .kxKeyReq(kxKeyReq), .kxKeyWord(kxKeyWord), .kxKeyAddr(kxKeyAddr),
    .kxKeyValid(kxKeyValid), .kxKeyLast(kxKeyLast));
  acke_host_model host (.clk(clk), .reset_low(reset_low), .en(en), .kxEn(kxEn), .dataReq(dataReq), .dataWord(dataWord),
    .keyWord(keyWord), .kxKeyReq(kxKeyReq), .kxKeyValid(kxKeyValid), .kxKeyWord(kxKeyWord),
    .rawCipherWord(rawCipherWord));

  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk_idle();
    chk({dataReq, resultValid, kxKeyReq, kxKeyValid, kxKeyLast, resultWord, kxKeyWord, kxKeyAddr}, 0);
  endtask

  // Cycle bookkeeping of what the design shows, plus the hang limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (clr) begin
      {tReq, tRv, tRv2, rvCnt, kvCnt, krCnt} <= '0;
      lastSeen <= 1'b0;
      ovl <= 1'b0;
    end else begin
      if (dataReq === 1'b1 && tReq == 0) tReq <= cyc;
      if (resultValid === 1'b1 && en) begin
        if (tRv == 0) tRv <= cyc;
        if (rvCnt == 4) tRv2 <= cyc;
        if (rvCnt < 4) res <= {res[95:0], resultWord};
        if (dataReq === 1'b1) ovl <= 1'b1;
        rvCnt <= rvCnt + 1;
      end
      if (kxKeyValid === 1'b1 && kxEn && !lastSeen) kvCnt <= kvCnt + 1;
      if (kxKeyReq === 1'b1 && kxEn && !lastSeen) krCnt <= krCnt + 1;
      if (kxKeyLast === 1'b1 && !lastSeen) begin
        lastSeen <= 1'b1;
        lastAddr <= kxKeyAddr;
        lastWord <= kxKeyWord;
      end
    end
    // Hang limit, checked last so nothing follows the verdict
    if (cyc > 3000) begin
      n_errors++;
      stop_test();
    end
  end

  // One operation fed from the expander, optional stall and overlap
  task automatic run_row(input acke_row_s r, input int hold);
    // selector fixed for the whole run
    keyLengthSel <= r.ks;
    kxKsel <= r.ks;
    dir <= r.dr;
    kxDir <= r.dr;
    clr <= 1'b1;
    kxGo <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    go <= 1'b1;
    for (int i = 0; i < 400; i++) begin
      @(posedge clk);
      en <= (i >= r.st && i < r.st + 5) ? 1'b0 : 1'b1;
      kxEn <= (i >= r.st && i < r.st + 5) ? 1'b0 : 1'b1;
      if (hold > 0 && i == 5) dir <= 1'b1;
      if (rvCnt > hold) go <= 1'b0;
      if (lastSeen) kxGo <= 1'b0;
      if (lastSeen && rvCnt > hold) break;
    end
    @(posedge clk);
    go <= 1'b0;
    kxGo <= 1'b0;
    repeat (5) @(posedge clk);
    chk(tRv - tReq, r.n + (r.st < 0 ? 0 : 5));
    chk(rvCnt, hold > 0 ? 8 : 4);
    chk(ovl, 1'b1);
    chk(kvCnt, r.n);
    chk(krCnt, r.nk + 1);
    chk(lastAddr, r.dr ? 0 : r.n - 1);
    if (r.dr) chk(lastWord, 32'h00010203);
    if (!r.dr) chk(res, r.res);
  endtask

  initial begin
    acke_row_s r;
    repeat (10) @(posedge clk);
    @(negedge clk);
    chk_idle();
    @(posedge clk);
    reset_low <= 1'b1;
    en <= 1'b1;
    kxEn <= 1'b1;
    foreach (rows[k]) begin
      run_row(rows[k], 0);
      $display("row %0d done, mismatches %0d", k, n_errors);
    end
    r = rows[0];
    r.st = 12;
    run_row(r, 0);
    $display("stall done, mismatches %0d", n_errors);
    run_row(rows[0], 4);
    chk(tRv2 - tRv, 44);
    $display("overlap done, mismatches %0d", n_errors);
    // Trigger dropped in mid-run: no result may follow
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    go <= 1'b1;
    kxGo <= 1'b1;
    repeat (10) @(posedge clk);
    go <= 1'b0;
    kxGo <= 1'b0;
    repeat (70) @(posedge clk);
    chk(rvCnt, 0);
    chk(kvCnt < 12, 1'b1);
    $display("abort done, mismatches %0d", n_errors);
    go <= 1'b1;
    kxGo <= 1'b1;
    repeat (20) @(posedge clk);
    reset_low <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk_idle();
    @(posedge clk);
    reset_low <= 1'b1;
    go <= 1'b0;
    kxGo <= 1'b0;
    $display("reset done, mismatches %0d", n_errors);
    stop_test();
  end
endmodule
